// ---- fpcex_cond.sv ----
// Shared types and constants for the conditional execute block, plus the
// pure combinational condition evaluator. Assumes status arrives from flops.
package fpcex_pkg;
    localparam int REG_COUNT = 8;
    localparam int DATA_W = 32;
    localparam int INSTR_W = 32;
    localparam int ALU_OP_W = 14;
    localparam int COND_W = 5;
    localparam int SEL_W = 3;
    // Instruction field positions
    localparam int PREFIX_HI = 31;
    localparam int PREFIX_LO = 25;
    localparam int COND_HI = 24;
    localparam int COND_LO = 20;
    localparam int SRC_HI = 19;
    localparam int SRC_LO = 17;
    localparam int DST_HI = 16;
    localparam int DST_LO = 14;
    localparam int ALU_HI = 13;
    localparam int ALU_LO = 0;
    localparam logic [6:0] OPCODE_PREFIX = 7'h03;
    // Condition codes; bit 4 selects the complement
    localparam logic [3:0] CC_GT = 4'h0;
    localparam logic [3:0] CC_LT = 4'h1;
    localparam logic [3:0] CC_GE = 4'h2;
    localparam logic [3:0] CC_LE = 4'h3;
    localparam logic [3:0] CC_GL = 4'h4;
    localparam logic [3:0] CC_INF = 4'h5;
    localparam logic [3:0] CC_GLE = 4'h6;
    localparam logic [3:0] CC_OR = 4'h7;
    localparam logic [3:0] CC_EQ = 4'h8;
    localparam logic [3:0] CC_PL = 4'h9;
    localparam logic [3:0] CC_ERR = 4'hf;
    // Execution takes this many cycles when no wait state is inserted
    localparam int EXEC_CYCLES = 2;

    typedef struct packed {
        logic a;
        logic r;
        logic lr;
        logic i;
        logic n;
        logic z;
        logic v;
        logic c;
    } fpcex_ccr_t;

    typedef struct packed {
        logic unordered_test_flag;
        logic not_a_number_flag;
        logic signaling_not_number_flag;
        logic invalid_operation_flag;
        logic ovf;
        logic unf;
        logic dz;
        logic inexact_flag;
    } fpcex_er_t;

    typedef struct packed {
        logic sticky_invalid_op_flag;
        logic sovf;
        logic sunf;
        logic sdz;
        logic sinx;
    } fpcex_ier_t;

    localparam fpcex_ccr_t CCR_RESET = 8'h00;
    localparam fpcex_er_t ER_RESET = 8'h00;
    localparam fpcex_ier_t IER_RESET = 5'h00;
endpackage

`timescale 1ns/1ps

module fpcex_cond_eval (
    // Condition and status snapshot
    input wire logic [fpcex_pkg::COND_W-1:0] cond,
    input wire fpcex_pkg::fpcex_ccr_t cond_code_reg,
    input wire fpcex_pkg::fpcex_er_t er,
    // Evaluation result
    output logic condTrue,
    output logic nonAware,
    output logic condLegal
);
    import fpcex_pkg::*;

    logic baseTrue;
    logic baseLegal;
    wire complement = cond[4];
    wire [3:0] code = cond[3:0];
    wire gtExpr = er.not_a_number_flag | cond_code_reg.z | cond_code_reg.n;
    wire ltExpr = er.not_a_number_flag | cond_code_reg.z | ~cond_code_reg.n;
    wire geExpr = er.not_a_number_flag | (cond_code_reg.n & ~cond_code_reg.z);
    wire leExpr = er.not_a_number_flag | ~(cond_code_reg.n | cond_code_reg.z);
    wire glExpr = er.not_a_number_flag | cond_code_reg.z;
    wire errExpr = er.unordered_test_flag | er.signaling_not_number_flag | er.invalid_operation_flag | er.ovf | er.unf | er.dz;

    always_comb begin
        baseTrue = 1'b0;
        baseLegal = 1'b1;
        unique case (code)
            CC_GT: baseTrue = ~gtExpr;
            CC_LT: baseTrue = ~ltExpr;
            CC_GE: baseTrue = ~geExpr;
            CC_LE: baseTrue = ~leExpr;
            CC_GL: baseTrue = ~glExpr;
            CC_INF: baseTrue = cond_code_reg.i;
            CC_GLE, CC_OR: baseTrue = ~er.not_a_number_flag;
            CC_EQ: baseTrue = cond_code_reg.z;
            CC_PL: baseTrue = ~cond_code_reg.n;
            CC_ERR: begin
                baseTrue = errExpr;
                baseLegal = ~complement;
            end
            default: baseLegal = 1'b0;
        endcase
    end

    // Negated forms are the plain complement of the base relation
    assign condTrue = baseLegal & (complement ? ~baseTrue : baseTrue);
    assign condLegal = baseLegal;
    // Only the relational group and INF are blind to NaN; OR/UN test NaN directly
    assign nonAware = baseLegal & ~code[3] & (code != CC_OR);
endmodule

// ---- fpcex_exec.sv ----
// Top of the floating-point conditional execute block: decodes one word,
// tests the condition, then commits move, ALU result and status.
// Assumes the ALU result and status inputs are valid in the execute cycle.
`timescale 1ns/1ps

module fpcex_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instrValid,
    input wire logic [fpcex_pkg::INSTR_W-1:0] instr,
    input wire logic dataWait,
    output logic busy,
    output logic done,
    output logic illegal,
    // Parallel ALU side
    output logic [fpcex_pkg::ALU_OP_W-1:0] aluOp,
    input wire logic [fpcex_pkg::DATA_W-1:0] aluResult,
    input wire fpcex_pkg::fpcex_ccr_t aluCcr,
    input wire fpcex_pkg::fpcex_er_t aluEr,
    output logic aluCommit,
    output logic [fpcex_pkg::DATA_W-1:0] aluDest,
    // Register file load and observation
    input wire logic regLoad,
    input wire logic [fpcex_pkg::SEL_W-1:0] regLoadSel,
    input wire logic [fpcex_pkg::DATA_W-1:0] regLoadData,
    input wire logic [fpcex_pkg::SEL_W-1:0] regReadSel,
    output logic [fpcex_pkg::DATA_W-1:0] regReadData,
    // Status registers
    output fpcex_pkg::fpcex_ccr_t condCodeReg,
    output fpcex_pkg::fpcex_er_t exceptionStatusReg,
    output fpcex_pkg::fpcex_ier_t stickyFlagReg,
    output logic condResult
);
    import fpcex_pkg::*;

    typedef enum logic [1:0] {
        FPCEX_IDLE = 2'b00,
        FPCEX_EVAL = 2'b01,
        FPCEX_EXEC = 2'b10
    } fpcex_state_t;

    fpcex_state_t state;
    fpcex_state_t next_state;
    logic [DATA_W-1:0] regs [REG_COUNT];
    logic [SEL_W-1:0] srcSel;
    logic [SEL_W-1:0] dstSel;
    logic passLatched;
    logic uncLatched;
    logic evalTrue;
    logic evalNonAware;
    logic evalLegal;

    // Field decode of the incoming word
    wire [6:0] prefixField = instr[PREFIX_HI:PREFIX_LO];
    wire [COND_W-1:0] condField = instr[COND_HI:COND_LO];
    wire [SEL_W-1:0] srcField = instr[SRC_HI:SRC_LO];
    wire [SEL_W-1:0] dstField = instr[DST_HI:DST_LO];
    wire [ALU_OP_W-1:0] aluField = instr[ALU_HI:ALU_LO];

    // Evaluated against current status, before this word's ALU result lands
    fpcex_cond_eval u_eval (
        .cond(condField),
        .cond_code_reg(condCodeReg),
        .er(exceptionStatusReg),
        .condTrue(evalTrue),
        .nonAware(evalNonAware),
        .condLegal(evalLegal)
    );

    wire prefixOk = (prefixField == OPCODE_PREFIX);
    wire accept = (state == FPCEX_IDLE) && instrValid;
    wire acceptGood = accept && prefixOk && evalLegal;
    // NaN seen by a relation that cannot report unordered
    wire uncEvent = evalNonAware & exceptionStatusReg.not_a_number_flag;
    wire execStep = (state == FPCEX_EXEC) && !dataWait;
    wire commitGo = execStep && passLatched;

    always_comb begin
        next_state = state;
        unique case (state)
            FPCEX_IDLE: if (acceptGood) next_state = FPCEX_EVAL;
            FPCEX_EVAL: next_state = FPCEX_EXEC;
            FPCEX_EXEC: if (!dataWait) next_state = FPCEX_IDLE;
            default: next_state = FPCEX_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= FPCEX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Latch the decoded word and the test outcome at issue
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            srcSel <= '0;
            dstSel <= '0;
            aluOp <= '0;
            passLatched <= 1'b0;
            uncLatched <= 1'b0;
            condResult <= 1'b0;
        end else if (acceptGood) begin
            srcSel <= srcField;
            dstSel <= dstField;
            aluOp <= aluField;
            passLatched <= evalTrue;
            uncLatched <= uncEvent;
            condResult <= evalTrue;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            illegal <= 1'b0;
            done <= 1'b0;
            aluCommit <= 1'b0;
        end else begin
            illegal <= accept && !(prefixOk && evalLegal);
            done <= execStep;
            aluCommit <= commitGo;
        end
    end

    // Register file; a 0-to-0 move is a harmless self copy
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < REG_COUNT; k++) begin
                regs[k] <= '0;
            end
        end else if (commitGo) begin
            regs[dstSel] <= regs[srcSel];
        end else if (regLoad && state == FPCEX_IDLE) begin
            regs[regLoadSel] <= regLoadData;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regReadData <= '0;
            aluDest <= '0;
        end else begin
            regReadData <= regs[regReadSel];
            if (commitGo) begin
                aluDest <= aluResult;
            end
        end
    end

    // Status commit; false condition leaves all but the unordered side effect
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            condCodeReg <= CCR_RESET;
            exceptionStatusReg <= ER_RESET;
            stickyFlagReg <= IER_RESET;
        end else if (execStep) begin
            if (passLatched) begin
                condCodeReg <= aluCcr;
                exceptionStatusReg <= aluEr;
                // The ALU never owns the unordered-test bit
                exceptionStatusReg.unordered_test_flag <= exceptionStatusReg.unordered_test_flag | uncLatched;
                stickyFlagReg.sinx <= stickyFlagReg.sinx | aluEr.inexact_flag;
                stickyFlagReg.sdz <= stickyFlagReg.sdz | aluEr.dz;
                stickyFlagReg.sunf <= stickyFlagReg.sunf | aluEr.unf;
                stickyFlagReg.sovf <= stickyFlagReg.sovf | aluEr.ovf;
                stickyFlagReg.sticky_invalid_op_flag <= stickyFlagReg.sticky_invalid_op_flag | aluEr.invalid_operation_flag | aluEr.signaling_not_number_flag
                    | uncLatched;
            end else if (uncLatched) begin
                exceptionStatusReg.unordered_test_flag <= 1'b1;
                stickyFlagReg.sticky_invalid_op_flag <= 1'b1;
            end
        end
    end

    assign busy = (state != FPCEX_IDLE);
endmodule

// ---- fpcex_exec_sva.sv ----
// Checker for the conditional execute top; sees its ports only.
// Assumes the bench holds ALU inputs steady through each instruction.
`timescale 1ns/1ps

module fpcex_exec_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Handshake
    input wire logic busy,
    input wire logic done,
    input wire logic illegal,
    // ALU side
    input wire logic [fpcex_pkg::DATA_W-1:0] aluResult,
    input wire fpcex_pkg::fpcex_ccr_t aluCcr,
    input wire fpcex_pkg::fpcex_er_t aluEr,
    input wire logic aluCommit,
    input wire logic [fpcex_pkg::DATA_W-1:0] aluDest,
    // Status
    input wire fpcex_pkg::fpcex_ccr_t condCodeReg,
    input wire fpcex_pkg::fpcex_er_t exceptionStatusReg,
    input wire fpcex_pkg::fpcex_ier_t stickyFlagReg,
    input wire logic condResult
);
    import fpcex_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    done_pulse_a: assert property (done |=> !done)
        else $error("done too long");
    busy_done_a: assert property ($fell(busy) |-> done)
        else $error("done late");
    commit_true_a: assert property (aluCommit |-> done && condResult)
        else $error("commit without true test");
    commit_data_a: assert property (aluCommit |-> aluDest == $past(aluResult))
        else $error("wrong committed data");
    commit_status_a: assert property (aluCommit |-> condCodeReg == $past(aluCcr)
        && ((exceptionStatusReg ^ $past(aluEr)) & 8'h7f) == 8'h00)
        else $error("wrong committed status");
    false_hold_a: assert property (done && !aluCommit |-> condCodeReg == $past(condCodeReg))
        else $error("status moved on false test");
    quiet_status_a: assert property (!done |-> $stable(condCodeReg) && $stable(stickyFlagReg))
        else $error("status moved while idle");
    quiet_er_a: assert property (!done |-> $stable(exceptionStatusReg))
        else $error("exception status moved while idle");
    sticky_grow_a: assert property ((stickyFlagReg & $past(stickyFlagReg)) == $past(stickyFlagReg))
        else $error("sticky flag cleared");
    unordered_test_flag_kept_a: assert property (($past(exceptionStatusReg) & 8'h80) != 8'h00 |-> exceptionStatusReg.unordered_test_flag)
        else $error("unordered flag cleared");
    illegal_idle_a: assert property (illegal |-> !busy && !done)
        else $error("refused word started");
endmodule

// ---- fpcex_exec_tb_top.sv ----
// Bench for the conditional execute top: every condition code over
// several status patterns. Assumes the checker bound at the foot.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errors++; $display("wrong value %s expected %h seen %h", nm, e, g); end end

module fpcex_exec_tb_top;
    import fpcex_pkg::*;
    logic clock = 1'h0;
    logic rst_n = 1'h1;
    logic instrValid = 1'h0;
    logic [INSTR_W-1:0] instr = 32'h0;
    logic dataWait = 1'h0;
    logic [DATA_W-1:0] aluResult = 32'h0;
    fpcex_ccr_t aluCcr = 8'h00;
    fpcex_er_t aluEr = 8'h00;
    logic regLoad = 1'h0;
    logic [SEL_W-1:0] regLoadSel = 3'h0;
    logic [DATA_W-1:0] regLoadData = 32'h0;
    logic [SEL_W-1:0] regReadSel = 3'h5;
    logic busy, done, illegal, aluCommit, condResult;
    logic [ALU_OP_W-1:0] aluOp;
    logic [DATA_W-1:0] aluDest, regReadData;
    fpcex_ccr_t condCodeReg, expCcr, pq;
    fpcex_er_t exceptionStatusReg, expEr, pe;
    fpcex_ier_t stickyFlagReg, expIer;
    logic [DATA_W-1:0] expReg [REG_COUNT];
    logic [DATA_W-1:0] expDest;
    int errors = 0;
    int cmpCount = 0;

    fpcex_exec dut (.clock(clock), .rst_n(rst_n), .instrValid(instrValid), .instr(instr),
        .dataWait(dataWait), .busy(busy), .done(done), .illegal(illegal), .aluOp(aluOp),
        .aluResult(aluResult), .aluCcr(aluCcr), .aluEr(aluEr), .aluCommit(aluCommit),
        .aluDest(aluDest), .regLoad(regLoad), .regLoadSel(regLoadSel),
        .regLoadData(regLoadData), .regReadSel(regReadSel), .regReadData(regReadData),
        .condCodeReg(condCodeReg), .exceptionStatusReg(exceptionStatusReg),
        .stickyFlagReg(stickyFlagReg), .condResult(condResult));

    initial forever #12.5 clock = ~clock;

    // Returns {outcome, non-aware}
    function automatic logic [1:0] ev(input logic [4:0] c, input fpcex_ccr_t q,
                                      input fpcex_er_t e);
        logic t;
        case (c[3:0])
            CC_GT: t = !(e.not_a_number_flag | q.z | q.n);
            CC_LT: t = !(e.not_a_number_flag | q.z | !q.n);
            CC_GE: t = !(e.not_a_number_flag | (q.n & !q.z));
            CC_LE: t = !(e.not_a_number_flag | !(q.n | q.z));
            CC_GL: t = !(e.not_a_number_flag | q.z);
            CC_INF: t = q.i;
            CC_GLE, CC_OR: t = !e.not_a_number_flag;
            CC_EQ: t = q.z;
            CC_PL: t = !q.n;
            default: t = e.unordered_test_flag | e.signaling_not_number_flag | e.invalid_operation_flag | e.ovf | e.unf | e.dz;
        endcase
        return {t ^ (c[4] & c[3:0] != CC_ERR), !(c[3] | c[3:0] == CC_OR)};
    endfunction

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(posedge clock);
        rst_n <= 1'h0;
        repeat (6) @(posedge clock);
        rst_n <= 1'h1;
        expCcr = CCR_RESET;
        expEr = ER_RESET;
        expIer = IER_RESET;
        expDest = '0;
        for (int i = 0; i < REG_COUNT; i++) begin
            @(posedge clock);
            regLoad <= 1'h1;
            regLoadSel <= 3'(i);
            regLoadData <= 32'h00a00000 + 32'(i);
            expReg[i] = 32'h00a00000 + 32'(i);
        end
        @(posedge clock);
        regLoad <= 1'h0;
    endtask

    task automatic run(input logic [4:0] c, input fpcex_ccr_t q, input fpcex_er_t e, input int w,
                       input logic [2:0] s, input logic [2:0] d);
        logic [1:0] r;
        logic nw;
        int n;
        r = ev(c, expCcr, expEr);
        nw = r[0] & expEr.not_a_number_flag;
        n = 0;
        @(posedge clock);
        instrValid <= 1'h1;
        instr <= {OPCODE_PREFIX, c, s, d, 9'h0, c};
        aluCcr <= q;
        aluEr <= e;
        aluResult <= {e, q, 11'h0, c};
        @(posedge clock);
        instrValid <= 1'h0;
        if (c[3:0] > 4'h9 && c != 5'h0f) begin
            #1;
            `CHK("illegal", 1'h1, illegal)
            return;
        end
        while (n < 20) begin
            @(posedge clock);
            n++;
            if (n == 1 && w > 0) dataWait <= 1'h1;
            if (n == 1 + w && w > 0) dataWait <= 1'h0;
            #1;
            if (done === 1'h1) break;
        end
        `CHK("latency", EXEC_CYCLES + w, n)
        `CHK("busy", 1'h0, busy)
        `CHK("condResult", r[1], condResult)
        `CHK("aluCommit", r[1], aluCommit)
        `CHK("aluOp", {9'h0, c}, aluOp)
        if (r[1]) begin
            expDest = {e, q, 11'h0, c};
            expCcr = q;
            expEr = {expEr.unordered_test_flag | nw, e[6:0]};
            expIer = expIer | {e.invalid_operation_flag | e.signaling_not_number_flag | nw, e.ovf, e.unf, e.dz, e.inexact_flag};
            expReg[d] = expReg[s];
        end else begin
            expEr.unordered_test_flag = expEr.unordered_test_flag | nw;
            expIer.sticky_invalid_op_flag = expIer.sticky_invalid_op_flag | nw;
        end
        `CHK("aluDest", expDest, aluDest)
        `CHK("ccr", expCcr, condCodeReg)
        `CHK("er", expEr, exceptionStatusReg)
        `CHK("ier", expIer, stickyFlagReg)
        @(posedge clock);
        #1;
        `CHK("reg", expReg[5], regReadData)
    endtask

    initial begin
        // Initialisers raise no event, so the first reset edge is made here
        rst_n <= 1'h0;
        for (int k = 0; k < 8; k++) begin
            do_reset();
            pq = {3'h0, k[2] ^ k[0], k[0], k[1], 2'h0};
            pe = {1'h0, k[2], 2'h0, k[0] & k[1], 3'h0};
            for (int c = 0; c < 32; c++) begin
                run(expEr.not_a_number_flag ? 5'h17 : 5'h07, pq, pe, 0, 3'h0, 3'h0);
                run(5'(c), ~pq, {1'h1, ~pe[6:0]}, c % 3, 3'(c), 3'h5);
            end
        end
        // A word with a foreign prefix must be refused, stay idle and leave the condition codes alone
        @(posedge clock);
        instrValid <= 1'h1;
        instr <= {~OPCODE_PREFIX, 5'h07, 6'h00, 9'h0, 5'h07};
        @(posedge clock);
        instrValid <= 1'h0;
        #1;
        `CHK("illegal", 1'h1, illegal)
        @(posedge clock);
        #1;
        `CHK("busy", 1'h0, busy)
        `CHK("done", 1'h0, done)
        `CHK("ccr", expCcr, condCodeReg)
        complete_run();
    end

    // Sized well beyond the roughly 2600 cycles the tests need
    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        complete_run();
    end
endmodule

bind fpcex_exec fpcex_exec_sva chk (.clock(clock), .rst_n(rst_n), .busy(busy), .done(done),
    .illegal(illegal), .aluResult(aluResult), .aluCcr(aluCcr), .aluEr(aluEr),
    .aluCommit(aluCommit), .aluDest(aluDest), .condCodeReg(condCodeReg),
    .exceptionStatusReg(exceptionStatusReg), .stickyFlagReg(stickyFlagReg),
    .condResult(condResult));
